// ===== common/apg_consts.vh
`ifndef APG_CONSTS_VH
`define APG_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte addresses (within the decoded 20-bit space)
// ----------------------------------------------------------------------------
`define APG_ADDR_REF_CTRL     20'he0560
`define APG_ADDR_P0_DIR       20'hfff20
`define APG_ADDR_P2_DIR       20'hfff22
`define APG_ADDR_P14_DIR      20'hfff2e
`define APG_ADDR_P0_ASEL      20'hf0060
`define APG_ADDR_P14_ASEL     20'hf006e
`define APG_ADDR_CONV_CFG     20'hf0076
`define APG_ADDR_AMP_CTRL     20'hf0550
`define APG_ADDR_AMP_CHAN     20'hf0551
`define APG_ADDR_CLK_GATE     20'hf0509
`define APG_ADDR_PIN_STATE    20'hf0600

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define APG_RST_DIR           8'hff
`define APG_RST_REF_CTRL      8'h00
`define APG_RST_ASEL          8'hff
`define APG_RST_ZERO          8'h00

// ----------------------------------------------------------------------------
// Bonded-bit masks of the registers (unbonded direction and select bits read as 1)
// ----------------------------------------------------------------------------
`define APG_P0_DIR_USED       8'h6c
`define APG_P2_DIR_USED       8'hf7
`define APG_P14_DIR_USED      8'h80
`define APG_P0_ASEL_USED      8'h0c
`define APG_P14_ASEL_USED     8'h80
`define APG_REF_CTRL_USED     8'h37
`define APG_AMP_CTRL_USED     8'h83
`define APG_AMP_CHAN_USED     8'h07
`define APG_CONV_CFG_USED     8'h0f

// ----------------------------------------------------------------------------
// Field positions and the prohibited channel code
// ----------------------------------------------------------------------------
`define APG_REF_GND_SEL_BIT   5
`define APG_REF_SUP_SEL_BIT   4
`define APG_AMP_EN_BIT        7
`define APG_CLK_EN_BIT        7
`define APG_CHAN_BAD          3'h7

`endif

// ===== core/apg_pin_amp_cfg.v
// Summary of operation
// - Analog select bit 1 means analog input.
// - Direction 0 output buffer on, 1 input.
// - Direction registers preset to all ones.
// - Direction registers take bit and byte writes.
// - Analog input pins read back as zero.
// - Output-direction pin never acts as analog.
// - Output latch ignored in analog mode.
// - Port 2 select and direction combine.
// - Port 0/14 select and direction combine.
// - Reference control clears, takes bit/byte writes.
// - Bit 5 selects reference ground source.
// - Bit 4 selects reference supply source.
// - Bits 0-2 enable three reference generators.
// - Amplifier offers gains four to thirty-two.
// - Gain code 00..11 gives x4..x32.
// - Channel codes 000..110; 111 prohibited.
// - Clock enable 0 resets amplifier, blocks writes.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
`include "apg_consts.vh"

module apg_pin_amp_cfg
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [19:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  // Port pins
  input  wire [7:0]  port0_pin_i,
  input  wire [7:0]  port2_pin_i,
  input  wire [7:0]  port14_pin_i,
  input  wire [7:0]  port0_latch_i,
  input  wire [7:0]  port2_latch_i,
  input  wire [7:0]  port14_latch_i,
  output reg  [7:0]  port0_pin_o,
  output reg  [7:0]  port2_pin_o,
  output reg  [7:0]  port14_pin_o,
  output reg  [7:0]  port0_pin_oe_o,
  output reg  [7:0]  port2_pin_oe_o,
  output reg  [7:0]  port14_pin_oe_o,
  // Analog routing
  output reg  [7:0]  port0_analog_o,
  output reg  [7:0]  port2_analog_o,
  output reg  [7:0]  port14_analog_o,
  output reg         ref_ground_is_pin_o,
  output reg         ref_supply_is_pin_o,
  output reg  [2:0]  ref_gen_enable_o,
  output reg         gain_amp_enable_o,
  output reg  [5:0]  gain_factor_o,
  output reg  [2:0]  gain_amp_channel_o,
  output reg         gain_amp_reset_o
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Merge a written byte into a register: bits outside the used mask take
  // the fill value, so a bit with no pin behind it can never be cleared.
  // Every register is decoded at its full byte address but always takes its data from byte lane 0, so only that lane counts.
  function [7:0] apg_merge;
    input [7:0] old_val;
    input [7:0] wdat;
    input [7:0] used;
    input [7:0] fill;
    begin
      apg_merge = (wdat & used) | (fill & ~used);
    end
  endfunction

  // Analog only when selected analog and direction is input.
  function [7:0] apg_analog;
    input [7:0] asel;
    input [7:0] dir;
    begin
      apg_analog = asel & dir;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [7:0] p0_dir_reg;
  reg  [7:0] p2_dir_reg;
  reg  [7:0] p14_dir_reg;
  reg  [7:0] p0_asel_reg;
  reg  [7:0] p14_asel_reg;
  reg  [3:0] conv_cfg_reg;
  reg  [7:0] ref_ctrl_reg;
  reg  [7:0] amp_ctrl_reg;
  reg  [2:0] amp_chan_reg;
  reg        clk_gate_reg;
  reg  [7:0] p0_s1_reg;
  reg  [7:0] p0_s2_reg;
  reg  [7:0] p0_s3_reg;
  reg  [7:0] p0_in_reg;
  reg  [7:0] p2_s1_reg;
  reg  [7:0] p2_s2_reg;
  reg  [7:0] p2_s3_reg;
  reg  [7:0] p2_in_reg;
  reg  [7:0] p14_s1_reg;
  reg  [7:0] p14_s2_reg;
  reg  [7:0] p14_s3_reg;
  reg  [7:0] p14_in_reg;

  wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire       lane0    = wb_sel_i[0];
  wire       wr       = req & wb_we_i & lane0;
  wire [7:0] wd       = wb_dat_i[7:0];
  wire       amp_wr_ok = clk_gate_reg;

  // --------------------------------------------------------------------------
  // Analog mode decode
  // --------------------------------------------------------------------------
  // Port 2 analog set from the converter pin configuration: pins below the
  // boundary are analog.  Bit 3 stands for the internal amplifier node.
  // Unlisted codes are prohibited; they fall back to all digital so that no
  // pin turns analog by accident.
  reg  [7:0] p2_asel;
  always @*
  begin
    case (conv_cfg_reg)
      4'h0, 4'h9, 4'hf: p2_asel = 8'hff;
      4'h1:             p2_asel = 8'h00;
      4'h2:             p2_asel = 8'h01;
      4'h3:             p2_asel = 8'h03;
      4'h4:             p2_asel = 8'h07;
      4'h5:             p2_asel = 8'h0f;
      4'h6:             p2_asel = 8'h1f;
      4'h7:             p2_asel = 8'h3f;
      4'h8:             p2_asel = 8'h7f;
      default:          p2_asel = 8'h00;
    endcase
  end

  wire [7:0] p0_ana  = apg_analog(p0_asel_reg & `APG_P0_ASEL_USED, p0_dir_reg);
  wire [7:0] p2_ana  = apg_analog(p2_asel, p2_dir_reg);
  wire [7:0] p14_ana = apg_analog(p14_asel_reg & `APG_P14_ASEL_USED, p14_dir_reg);

  // --------------------------------------------------------------------------
  // Register read decode
  // --------------------------------------------------------------------------
  // An unmapped address is answered with an error, so that a stray access is
  // seen by software instead of quietly reading as zero.
  reg        hit;
  reg  [7:0] rdat;
  always @*
  begin
    hit  = 1'b1;
    rdat = 8'h00;
    case (wb_adr_i)
      `APG_ADDR_P0_DIR:    rdat = p0_dir_reg;
      `APG_ADDR_P2_DIR:    rdat = p2_dir_reg;
      `APG_ADDR_P14_DIR:   rdat = p14_dir_reg;
      `APG_ADDR_P0_ASEL:   rdat = p0_asel_reg;
      `APG_ADDR_P14_ASEL:  rdat = p14_asel_reg;
      `APG_ADDR_CONV_CFG:  rdat = {4'h0, conv_cfg_reg};
      `APG_ADDR_REF_CTRL:  rdat = ref_ctrl_reg;
      `APG_ADDR_AMP_CTRL:  rdat = amp_ctrl_reg;
      `APG_ADDR_AMP_CHAN:  rdat = {5'h00, amp_chan_reg};
      `APG_ADDR_CLK_GATE:  rdat = {clk_gate_reg, 7'h00};
      // Analog pins read as zero whatever their level.
      `APG_ADDR_PIN_STATE: rdat = 8'h00;
      default:             hit  = 1'b0;
    endcase
  end

  // Pin level view, one byte per port packed in bytes 0..2.
  wire [23:0] pin_view = {p14_in_reg & ~p14_ana, p2_in_reg & ~p2_ana, p0_in_reg & ~p0_ana};

  // --------------------------------------------------------------------------
  // Bus and register update
  // --------------------------------------------------------------------------
  // A request is taken on the edge that sees cyc and stb with no answer
  // pending; the write lands on that same edge and the answer follows one
  // cycle later.  The answer itself blocks a second take, so a master that
  // holds its request until it sees ack never writes twice.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      p0_dir_reg   <= `APG_RST_DIR;
      p2_dir_reg   <= `APG_RST_DIR;
      p14_dir_reg  <= `APG_RST_DIR;
      p0_asel_reg  <= `APG_RST_ASEL;
      p14_asel_reg <= `APG_RST_ASEL;
      conv_cfg_reg <= 4'h0;
      ref_ctrl_reg <= `APG_RST_REF_CTRL;
      amp_ctrl_reg <= `APG_RST_ZERO;
      amp_chan_reg <= 3'h0;
      clk_gate_reg <= 1'b0;
      wb_ack_o     <= 1'b0;
      wb_err_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      if (req)
      begin
        if (wb_adr_i == `APG_ADDR_PIN_STATE)
          wb_dat_o <= {8'h00, pin_view};
        else
          wb_dat_o <= {24'h000000, rdat};
      end
      // A byte write covers the single-bit form: software read-modify-writes.
      if (wr)
      begin
        case (wb_adr_i)
          `APG_ADDR_P0_DIR:   p0_dir_reg  <= apg_merge(p0_dir_reg, wd, `APG_P0_DIR_USED, 8'hff);
          `APG_ADDR_P2_DIR:   p2_dir_reg  <= apg_merge(p2_dir_reg, wd, `APG_P2_DIR_USED, 8'hff);
          `APG_ADDR_P14_DIR:  p14_dir_reg <= apg_merge(p14_dir_reg, wd, `APG_P14_DIR_USED, 8'hff);
          `APG_ADDR_P0_ASEL:  p0_asel_reg  <= apg_merge(p0_asel_reg, wd, `APG_P0_ASEL_USED, 8'hff);
          `APG_ADDR_P14_ASEL: p14_asel_reg <= apg_merge(p14_asel_reg, wd, `APG_P14_ASEL_USED, 8'hff);
          `APG_ADDR_CONV_CFG: conv_cfg_reg <= wd[3:0];
          `APG_ADDR_REF_CTRL:
            if (amp_wr_ok)
              ref_ctrl_reg <= wd & `APG_REF_CTRL_USED;
          `APG_ADDR_AMP_CTRL:
            if (amp_wr_ok)
              amp_ctrl_reg <= wd & `APG_AMP_CTRL_USED;
          `APG_ADDR_AMP_CHAN:
            if (amp_wr_ok && wd[2:0] != `APG_CHAN_BAD)
              amp_chan_reg <= wd[2:0];
          `APG_ADDR_CLK_GATE: clk_gate_reg <= wd[`APG_CLK_EN_BIT];
          default: ;
        endcase
      end
      // Gating the clock off puts the amplifier registers back in reset.
      // The clear repeats on every gated cycle, so the registers stay at their
      // reset values for as long as the clock is held off.
      if (!clk_gate_reg)
      begin
        ref_ctrl_reg <= `APG_RST_REF_CTRL;
        amp_ctrl_reg <= `APG_RST_ZERO;
        amp_chan_reg <= 3'h0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin input synchronisers
  // --------------------------------------------------------------------------
  // Three stages; a change is taken only when stages two and three agree.
  // The agreement costs a cycle of latency on pin reads, but a one-cycle
  // glitch on a pin never reaches software.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      p0_s1_reg  <= 8'h00;
      p0_s2_reg  <= 8'h00;
      p0_s3_reg  <= 8'h00;
      p0_in_reg  <= 8'h00;
      p2_s1_reg  <= 8'h00;
      p2_s2_reg  <= 8'h00;
      p2_s3_reg  <= 8'h00;
      p2_in_reg  <= 8'h00;
      p14_s1_reg <= 8'h00;
      p14_s2_reg <= 8'h00;
      p14_s3_reg <= 8'h00;
      p14_in_reg <= 8'h00;
    end
    else
    begin
      p0_s1_reg  <= port0_pin_i;
      p0_s2_reg  <= p0_s1_reg;
      p0_s3_reg  <= p0_s2_reg;
      p0_in_reg  <= (p0_s2_reg & p0_s3_reg) | (p0_in_reg & (p0_s2_reg | p0_s3_reg));
      p2_s1_reg  <= port2_pin_i;
      p2_s2_reg  <= p2_s1_reg;
      p2_s3_reg  <= p2_s2_reg;
      p2_in_reg  <= (p2_s2_reg & p2_s3_reg) | (p2_in_reg & (p2_s2_reg | p2_s3_reg));
      p14_s1_reg <= port14_pin_i;
      p14_s2_reg <= p14_s1_reg;
      p14_s3_reg <= p14_s2_reg;
      p14_in_reg <= (p14_s2_reg & p14_s3_reg) | (p14_in_reg & (p14_s2_reg | p14_s3_reg));
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive and analog control outputs
  // --------------------------------------------------------------------------
  // Every output here is registered, so a register write shows one cycle
  // after the bus answer.  The analog flag needs both the select and the
  // input direction, so a driven pin can never be routed as analog input.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port0_pin_o         <= 8'h00;
      port2_pin_o         <= 8'h00;
      port14_pin_o        <= 8'h00;
      port0_pin_oe_o      <= 8'h00;
      port2_pin_oe_o      <= 8'h00;
      port14_pin_oe_o     <= 8'h00;
      port0_analog_o      <= 8'h00;
      port2_analog_o      <= 8'h00;
      port14_analog_o     <= 8'h00;
      ref_ground_is_pin_o <= 1'b0;
      ref_supply_is_pin_o <= 1'b0;
      ref_gen_enable_o    <= 3'h0;
      gain_amp_enable_o   <= 1'b0;
      gain_factor_o       <= 6'h04;
      gain_amp_channel_o  <= 3'h0;
      gain_amp_reset_o    <= 1'b1;
    end
    else
    begin
      // Latches pass through; they never touch the analog path.
      port0_pin_o         <= port0_latch_i;
      port2_pin_o         <= port2_latch_i;
      port14_pin_o        <= port14_latch_i;
      port0_pin_oe_o      <= ~p0_dir_reg;
      port2_pin_oe_o      <= ~p2_dir_reg;
      port14_pin_oe_o     <= ~p14_dir_reg;
      port0_analog_o      <= p0_ana;
      port2_analog_o      <= p2_ana;
      port14_analog_o     <= p14_ana;
      ref_ground_is_pin_o <= ref_ctrl_reg[`APG_REF_GND_SEL_BIT];
      ref_supply_is_pin_o <= ref_ctrl_reg[`APG_REF_SUP_SEL_BIT];
      ref_gen_enable_o    <= ref_ctrl_reg[2:0];
      gain_amp_enable_o   <= amp_ctrl_reg[`APG_AMP_EN_BIT] & clk_gate_reg;
      gain_factor_o       <= 6'h04 << amp_ctrl_reg[1:0];
      gain_amp_channel_o  <= amp_chan_reg;
      gain_amp_reset_o    <= ~clk_gate_reg;
    end
  end

endmodule // apg_pin_amp_cfg

// ===== tb/apg_pin_amp_cfg_checker.sv
`timescale 1ns/100ps
`include "apg_consts.vh"
module apg_chk
(
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [19:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // Pin and analog outputs
  input wire logic [7:0]  port0_pin_oe_o,
  input wire logic [7:0]  port2_pin_oe_o,
  input wire logic [7:0]  port14_pin_oe_o,
  input wire logic [7:0]  port0_analog_o,
  input wire logic [7:0]  port2_analog_o,
  input wire logic [7:0]  port14_analog_o,
  input wire logic        ref_ground_is_pin_o,
  input wire logic        ref_supply_is_pin_o,
  input wire logic [2:0]  ref_gen_enable_o,
  input wire logic        gain_amp_enable_o,
  input wire logic [5:0]  gain_factor_o,
  input wire logic [2:0]  gain_amp_channel_o,
  input wire logic        gain_amp_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [7:0] oe_all = port0_pin_oe_o | port2_pin_oe_o | port14_pin_oe_o;
  wire [4:0] ref_bits = {wb_dat_i[5:4], wb_dat_i[2:0]};
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  // The gate must be open on both cycles, otherwise the write is legally dropped.
  sequence s_ref_wr;
    s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == `APG_ADDR_REF_CTRL && !gain_amp_reset_o) ##1 !gain_amp_reset_o;
  endsequence
  property p_answer;
    s_take |=> wb_ack_o ^ wb_err_o;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_pulse;
    wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_excl;
    ((port0_pin_oe_o & port0_analog_o) | (port2_pin_oe_o & port2_analog_o) | (port14_pin_oe_o & port14_analog_o)) == 8'h00;
  endproperty
  a_excl: assert property (p_excl) else $error("driven pin marked analog");
  property p_unbonded;
    (port0_pin_oe_o & 8'h93) == 8'h00 && !port2_pin_oe_o[3] && port14_pin_oe_o[6:0] == 7'h00;
  endproperty
  a_unbonded: assert property (p_unbonded) else $error("unbonded pin driven");
  property p_gain;
    gain_factor_o inside {6'h04, 6'h08, 6'h10, 6'h20};
  endproperty
  a_gain: assert property (p_gain) else $error("illegal gain");
  property p_chan;
    gain_amp_channel_o != `APG_CHAN_BAD;
  endproperty
  a_chan: assert property (p_chan) else $error("prohibited channel");
  // Two held cycles: the registered outputs still show the old setting on the first one.
  property p_gate;
    gain_amp_reset_o && $past(gain_amp_reset_o) |-> !gain_amp_enable_o && ref_gen_enable_o == 3'h0 &&
      !ref_ground_is_pin_o && !ref_supply_is_pin_o && gain_amp_channel_o == 3'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("amplifier on while held");
  property p_rst_dir;
    disable iff (1'b0) $fell(rst_i) |-> oe_all == 8'h00 ##1 oe_all == 8'h00;
  endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("pin driven after reset");
  property p_ref_wr;
    s_ref_wr |=> {ref_ground_is_pin_o, ref_supply_is_pin_o, ref_gen_enable_o} == $past(ref_bits, 2);
  endproperty
  a_ref_wr: assert property (p_ref_wr) else $error("reference outputs wrong");
endmodule // apg_chk

bind apg_pin_amp_cfg apg_chk apg_chk_inst (.*);

// ===== tb/apg_pin_amp_cfg_tb_top.sv
`timescale 1ns/100ps
`include "apg_consts.vh"
module apg_pin_amp_cfg_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_r = 1'b0;
  logic        we_r  = 1'b0;
  logic [19:0] adr_r = 20'h0;
  logic [31:0] dat_r = 32'h0;
  logic [3:0]  sel_r = 4'h0;
  logic [7:0]  pin_r [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0]  lat_r [3] = '{8'h00, 8'h00, 8'h00};
  wire  [31:0] rdat;
  wire         ack;
  wire         err;
  wire  [7:0]  po [3];
  wire  [7:0]  oe [3];
  wire  [7:0]  an [3];
  wire  [2:0]  gen;
  wire  [5:0]  gain;
  wire  [2:0]  chan;
  wire         gnd;
  wire         sup;
  wire         amp_en;
  wire         amp_rst;
  integer      err_total = 0;
  integer      checked = 0;
  integer      seed = 32'hd99fa344;
  logic [7:0]  m [9];
  logic        gate;
  logic [19:0] ma [9] = '{20'hfff20, 20'hfff22, 20'hfff2e, 20'hf0060, 20'hf006e, 20'hf0076, 20'he0560, 20'hf0550, 20'hf0551};
  logic [7:0]  um [9] = '{8'h6c, 8'hf7, 8'h80, 8'h0c, 8'h80, 8'h0f, 8'h37, 8'h83, 8'h07};
  logic [31:0] r;
  logic        e;
  logic [7:0]  d;
  int          i;

  always #25 clk_i = ~clk_i;

  apg_pin_amp_cfg apg_pin_amp_cfg_inst
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc_r), .wb_stb_i(cyc_r), .wb_we_i(we_r), .wb_adr_i(adr_r),
    .wb_sel_i(sel_r), .wb_dat_i(dat_r), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .port0_pin_i(pin_r[0]), .port2_pin_i(pin_r[1]), .port14_pin_i(pin_r[2]), .port0_latch_i(lat_r[0]),
    .port2_latch_i(lat_r[1]), .port14_latch_i(lat_r[2]), .port0_pin_o(po[0]), .port2_pin_o(po[1]),
    .port14_pin_o(po[2]), .port0_pin_oe_o(oe[0]), .port2_pin_oe_o(oe[1]), .port14_pin_oe_o(oe[2]),
    .port0_analog_o(an[0]), .port2_analog_o(an[1]), .port14_analog_o(an[2]), .ref_ground_is_pin_o(gnd),
    .ref_supply_is_pin_o(sup), .ref_gen_enable_o(gen), .gain_amp_enable_o(amp_en), .gain_factor_o(gain),
    .gain_amp_channel_o(chan), .gain_amp_reset_o(amp_rst)
  );

  // ----------------------------------------
  // Bus access, model and comparison
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Strobe and cycle share one driver, so they always rise and fall together.
  task automatic wb(input logic w, input logic [19:0] a, input logic [7:0] dd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_r <= 1'b1;
    we_r <= w;
    adr_r <= a;
    dat_r <= {24'h0, dd};
    sel_r <= 4'h1;
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1 && n++ < 40);
    r = rdat;
    e = err;
    cyc_r <= 1'b0;
    cmp({31'h0, n > 40}, 32'h0);
  endtask

  task automatic wr(input int k, input logic [7:0] dd);
    wb(1'b1, ma[k], dd);
    if (k < 6 || gate && !(k == 8 && dd[2:0] == 3'h7))
      m[k] = (dd & um[k]) | (k < 5 ? ~um[k] : 8'h00);
  endtask

  task automatic rd(input int k);
    wb(1'b0, ma[k], 8'h00);
    cmp(r, {24'h0, m[k]});
  endtask

  function automatic logic [7:0] amap(input logic [7:0] c);
    if (c == 8'h0 || c == 8'h9 || c == 8'hf)
      return 8'hff;
    return (c >= 8'h2 && c <= 8'h8) ? (8'h1 << (c - 8'h1)) - 8'h1 : 8'h00;
  endfunction

  task automatic ports;
    logic [7:0] a0;
    logic [7:0] a2;
    logic [7:0] a14;
    a0 = m[3] & m[0] & 8'h0c;
    a2 = amap(m[5]) & m[1];
    a14 = m[4] & m[2] & 8'h80;
    repeat (4) @(posedge clk_i);
    cmp({oe[0], oe[1], oe[2]}, {~m[0], ~m[1], ~m[2]});
    cmp({an[0], an[1], an[2]}, {a0, a2, a14});
    cmp({po[0], po[1], po[2]}, {lat_r[0], lat_r[1], lat_r[2]});
    wb(1'b0, 20'hf0600, 8'h00);
    cmp(r, {8'h00, pin_r[2] & ~a14, pin_r[1] & ~a2, pin_r[0] & ~a0});
  endtask

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    m = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    gate = 1'b0;
    for (int k = 0; k < 9; k++)
      rd(k);
  endtask

  task automatic set_gate(input logic g);
    wb(1'b1, 20'hf0509, {g, 7'h0});
    gate = g;
    for (int k = 6; k < 9 && !g; k++)
      m[k] = 8'h00;
  endtask

  task automatic amp_check;
    repeat (4) @(posedge clk_i);
    cmp({amp_rst, gnd, sup, gen, amp_en, gain, chan},
        {!gate, m[6][5:4], m[6][2:0], m[7][7], 6'h04 << m[7][1:0], m[8][2:0]});
  endtask

  task automatic close_out;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #500000;
    err_total++;
    close_out;
  end

  initial
  begin
    do_reset;
    ports;
    wb(1'b0, 20'h00010, 8'h00);
    cmp({31'h0, e}, 32'h1);
    for (int n = 0; n < 30; n++)
    begin
      i = $unsigned($random(seed)) % 6;
      d = 8'($random(seed));
      if (i == 5)
        d = (d[3:0] > 4'h9) ? 8'h0f : {4'h0, d[3:0]};
      for (int k = 0; k < 3; k++)
        {pin_r[k], lat_r[k]} <= 16'($random(seed));
      wr(i, d);
      rd(i);
      ports;
    end
    set_gate(1'b1);
    for (int k = 0; k < 4; k++)
    begin
      d = 8'($random(seed));
      wr(6, m[6] & 8'h30);
      wr(6, d & 8'h30);
      wr(6, d & 8'h37);
      repeat (200) @(posedge clk_i);
      rd(6);
      wr(7, 8'(k));
      amp_check;
      wr(7, 8'(k) | 8'h80);
      amp_check;
      wr(7, 8'(k));
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(8, 8'(k));
      rd(8);
    end
    // Amplifier start order, then the stop that must precede a restart.
    for (int k = 0; k < 2; k++)
    begin
      lat_r[0] <= lat_r[0] & 8'h9f;
      wr(5, 8'h09);
      wr(3, 8'hff);
      wr(4, 8'hff);
      wr(0, 8'h9f);
      wr(1, 8'hff);
      wr(2, 8'hff);
      wr(7, 8'(k + 2));
      wr(8, 8'(k + 5));
      wr(7, 8'(k + 2) | 8'h80);
      repeat (200) @(posedge clk_i);
      amp_check;
      ports;
      wr(7, 8'(k + 2));
    end
    set_gate(1'b0);
    wr(6, 8'h37);
    rd(6);
    amp_check;
    do_reset;
    amp_check;
    ports;
    close_out;
  end
endmodule // apg_pin_amp_cfg_tb_top
